// ===== logic/host_port_defs.svh
// Constants for the host port mode, reset and interrupt logic.
`ifndef HOST_PORT_DEFS_SVH
`define HOST_PORT_DEFS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define HP_ADDR_W        18
`define HP_DATA_W        16
`define HP_SUBSYS        2

// ****************************************************************
// Control register field positions
// ****************************************************************
`define HP_CTL_HOST2CPU_A 0
`define HP_CTL_HOST2CPU_B 1
`define HP_CTL_IRQ_FLAG_A 2
`define HP_CTL_IRQ_FLAG_B 3
`define HP_CTL_MODE       4
`define HP_CTL_RESET      16'h0000

// ****************************************************************
// Access select codes
// ****************************************************************
`define HP_SEL_CONTROL   2'h0
`define HP_SEL_DATA_INC  2'h1
`define HP_SEL_ADDRESS   2'h2
`define HP_SEL_DATA      2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define HP_CLK_PERIOD_NS 10
`define HP_MEM_TIMEOUT_NS 2000
`define HP_MEM_TIMEOUT_CYC (`HP_MEM_TIMEOUT_NS / `HP_CLK_PERIOD_NS)

`endif

// ===== logic/host_port_pkg.sv
// Types shared by the host port mode, reset and interrupt logic.
`include "host_port_defs.svh"

package host_port_pkg;

	// ****************************************************************
	// Host control strobes, sampled on the device clock except where the data output enable decodes them directly
	// ****************************************************************
	typedef struct packed {
		logic port_select_n;
		logic access_select_1;
		logic access_select_0;
		logic read_write;
		logic data_strobe_n;
		logic addr_strobe_n;
	} host_ctrl_t;

	// ****************************************************************
	// Word request towards the shared memory
	// ****************************************************************
	typedef struct packed {
		logic                  req;
		logic                  we;
		logic [`HP_ADDR_W-1:0] addr;
		logic [`HP_DATA_W-1:0] wdata;
	} mem_req_t;

	typedef enum logic [1:0] {
		PORT_IDLE,
		PORT_MEM_WAIT
	} port_state_t;

endpackage

// ===== logic/host_irq_flag.sv
// One sticky host interrupt flag with its active-low pin drive.
`timescale 1ns/100ps

module host_irq_flag (
	input  wire logic ref_clk_in,
	input  wire logic sys_rst_in,
	input  wire logic port_reset_in,
	input  wire logic enable_in,
	input  wire logic set_in,
	input  wire logic clear_in,
	input  wire logic float_n_in,
	output logic      flag_out,
	output logic      irq_n_out,
	output logic      irq_n_oe_out
);

	logic flag_reg;
	logic flag_next;

	// Set wins over a clear arriving in the same cycle.
	always_comb begin
		flag_next = enable_in & (set_in | (flag_reg & ~clear_in));
	end

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			flag_reg <= 1'b0;
		end else if (port_reset_in) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign flag_out     = flag_reg;
	assign irq_n_out    = ~flag_reg;
	assign irq_n_oe_out = float_n_in;

endmodule

// ===== logic/host_port_mode_irq_reset.sv
// Host port mode strap, reset fan-out, register access and interrupts.
`timescale 1ns/100ps
`include "host_port_defs.svh"

// Operation
// - Each subsystem drives its own active-low interrupt pin low.
// - Host writing one to a control flag bit releases that interrupt pin.
// - Host interrupt pins are only supported in multiplexed mode.
// - Output float input low puts both interrupt pins into high impedance.
// - Dedicated port reset clears port logic and resets both subsystems.
// - Mode pin low selects multiplexed access to control, address, data.
// - Multiplexed mode carries interrupts host to processor and back.
// - Mode pin high selects non-multiplexed mode with separate buses.
// - Non-multiplexed hosts use an 18-bit address and 16-bit data bus.
// - Non-multiplexed mode supports no interrupts either way.
// - Address strobe latches shared-bus address into the address register.
// - Ready tells host when the next transfer may start.
module host_port_mode_irq_reset
	import host_port_pkg::*;
#(
	parameter int ADDR_W      = `HP_ADDR_W,
	parameter int DATA_W      = `HP_DATA_W,
	parameter int MEM_TIMEOUT = `HP_MEM_TIMEOUT_CYC
) (
	input  wire logic              ref_clk_in,
	input  wire logic              sys_rst_in,
	input  wire logic              host_port_reset_n_in,
	input  wire logic              host_mux_select_in,
	input  wire logic              output_float_n_in,
	input  wire host_ctrl_t        host_ctrl_in,
	input  wire logic [ADDR_W-1:0] host_addr_in,
	input  wire logic [DATA_W-1:0] host_data_in,
	output logic      [DATA_W-1:0] host_data_out,
	output logic                   host_data_oe_out,
	output logic                   port_ready_out,
	output logic                   port_ready_oe_out,
	output logic                   host_irq_n_sub_a_out,
	output logic                   host_irq_n_sub_a_oe_out,
	output logic                   host_irq_n_sub_b_out,
	output logic                   host_irq_n_sub_b_oe_out,
	input  wire logic [1:0]        cpu_irq_set_in,
	output logic      [1:0]        cpu_irq_out,
	output logic      [1:0]        subsys_reset_out,
	output logic                   mux_mode_out,
	output mem_req_t               mem_req_out,
	input  wire logic [DATA_W-1:0] mem_rdata_in,
	input  wire logic              mem_ack_in
);

	// ****************************************************************
	// Strap capture and reset
	// ****************************************************************
	logic        strap_valid_reg;
	logic        nonmux_reg;
	logic [1:0]  subsys_reset_reg;
	logic        port_reset;
	logic        mux_mode;

	assign port_reset = ~host_port_reset_n_in;

	// The strap is caught on the first clean edge after reset so that an
	// asynchronous reset never loads the value of a pin.
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			strap_valid_reg <= 1'b0;
			nonmux_reg      <= 1'b0;
		end else if (port_reset) begin
			strap_valid_reg <= 1'b0;
		end else if (!strap_valid_reg) begin
			strap_valid_reg <= 1'b1;
			nonmux_reg      <= host_mux_select_in;
		end
	end

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			subsys_reset_reg <= 2'h3;
		end else begin
			subsys_reset_reg <= {2{port_reset}};
		end
	end

	assign mux_mode         = strap_valid_reg & ~nonmux_reg;
	assign mux_mode_out     = mux_mode;
	assign subsys_reset_out = subsys_reset_reg;

	// ****************************************************************
	// Strobe edge detection
	// ****************************************************************
	logic ds_n_reg;
	logic as_n_reg;
	logic selected;
	logic ds_fall;
	logic as_fall;

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ds_n_reg <= 1'b1;
			as_n_reg <= 1'b1;
		end else begin
			ds_n_reg <= host_ctrl_in.data_strobe_n;
			as_n_reg <= host_ctrl_in.addr_strobe_n;
		end
	end

	// Strobes outside an active port select are ignored.
	assign selected = ~host_ctrl_in.port_select_n & strap_valid_reg;
	assign ds_fall  = selected & ds_n_reg & ~host_ctrl_in.data_strobe_n;
	assign as_fall  = selected & as_n_reg & ~host_ctrl_in.addr_strobe_n;

	// ****************************************************************
	// Access decode
	// ****************************************************************
	port_state_t state_reg;
	logic [1:0]  sel;
	logic        acc_ctl;
	logic        acc_addr;
	logic        acc_data;
	logic        acc_write;
	logic        ready;

	assign ready    = (state_reg == PORT_IDLE) & strap_valid_reg;
	assign sel      = {host_ctrl_in.access_select_1,
	                   host_ctrl_in.access_select_0};
	// A data strobe while busy is dropped; the host must wait for ready.
	assign acc_ctl  = ds_fall & ready & mux_mode &
	                  (sel == `HP_SEL_CONTROL);
	assign acc_addr = ds_fall & ready & mux_mode & (sel == `HP_SEL_ADDRESS);
	assign acc_data = ds_fall & ready &
	                  (~mux_mode | sel == `HP_SEL_DATA |
	                   sel == `HP_SEL_DATA_INC);
	assign acc_write = ~host_ctrl_in.read_write;

	// ****************************************************************
	// Address register
	// ****************************************************************
	logic [ADDR_W-1:0] addr_reg;
	logic              inc_reg;

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			addr_reg <= '0;
		end else if (port_reset) begin
			addr_reg <= '0;
		end else if (mux_mode && as_fall) begin
			addr_reg <= ADDR_W'(host_data_in);
		end else if (acc_addr && acc_write) begin
			addr_reg <= ADDR_W'(host_data_in);
		end else if (mem_ack_in && state_reg == PORT_MEM_WAIT &&
		             inc_reg) begin
			addr_reg <= addr_reg + ADDR_W'(1);
		end
	end

	// ****************************************************************
	// Memory transfer sequencing
	// ****************************************************************
	mem_req_t    mem_reg;
	logic [31:0] wait_cnt_reg;
	logic        timeout;

	assign timeout = (wait_cnt_reg >= 32'(MEM_TIMEOUT - 1));

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_reg <= PORT_IDLE;
			mem_reg   <= '0;
			inc_reg   <= 1'b0;
		end else if (port_reset) begin
			state_reg <= PORT_IDLE;
			mem_reg   <= '0;
			inc_reg   <= 1'b0;
		end else begin
			case (state_reg)
				PORT_IDLE: begin
					if (acc_data) begin
						state_reg     <= PORT_MEM_WAIT;
						mem_reg.req   <= 1'b1;
						mem_reg.we    <= acc_write;
						mem_reg.wdata <= host_data_in;
						mem_reg.addr  <= mux_mode ? addr_reg : host_addr_in;
						inc_reg       <= mux_mode &
						                 (sel == `HP_SEL_DATA_INC);
					end
				end
				PORT_MEM_WAIT: begin
					// A stuck memory would otherwise hang the host forever.
					if (mem_ack_in || timeout) begin
						state_reg   <= PORT_IDLE;
						mem_reg.req <= 1'b0;
					end
				end
				default: begin
					state_reg <= PORT_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wait_cnt_reg <= '0;
		end else if (state_reg == PORT_MEM_WAIT && !mem_ack_in) begin
			wait_cnt_reg <= wait_cnt_reg + 32'h1;
		end else begin
			wait_cnt_reg <= '0;
		end
	end

	assign mem_req_out = mem_reg;

	// ****************************************************************
	// Interrupt flags towards the host
	// ****************************************************************
	logic [1:0] flag;
	logic [1:0] irq_n;
	logic [1:0] irq_n_oe;
	logic [1:0] flag_clear;
	logic       ctl_write;

	assign ctl_write  = acc_ctl & acc_write;
	assign flag_clear = {2{ctl_write}} &
	                    {host_data_in[`HP_CTL_IRQ_FLAG_B],
	                     host_data_in[`HP_CTL_IRQ_FLAG_A]};

	genvar gi;
	generate
		for (gi = 0; gi < `HP_SUBSYS; gi++) begin : g_irq
			host_irq_flag u_flag (
				.ref_clk_in    (ref_clk_in),
				.sys_rst_in    (sys_rst_in),
				.port_reset_in (port_reset),
				.enable_in     (mux_mode),
				.set_in        (cpu_irq_set_in[gi]),
				.clear_in      (flag_clear[gi]),
				.float_n_in    (output_float_n_in),
				.flag_out      (flag[gi]),
				.irq_n_out     (irq_n[gi]),
				.irq_n_oe_out  (irq_n_oe[gi])
			);
		end
	endgenerate

	assign host_irq_n_sub_a_out    = irq_n[0];
	assign host_irq_n_sub_a_oe_out = irq_n_oe[0];
	assign host_irq_n_sub_b_out    = irq_n[1];
	assign host_irq_n_sub_b_oe_out = irq_n_oe[1];

	// ****************************************************************
	// Interrupts towards the processors
	// ****************************************************************
	logic [1:0] cpu_irq_reg;

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cpu_irq_reg <= 2'h0;
		end else begin
			cpu_irq_reg <= {2{ctl_write & ~port_reset}} &
			               {host_data_in[`HP_CTL_HOST2CPU_B],
			                host_data_in[`HP_CTL_HOST2CPU_A]};
		end
	end

	assign cpu_irq_out = cpu_irq_reg;

	// ****************************************************************
	// Read data
	// ****************************************************************
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] ctl_value;

	always_comb begin
		ctl_value                     = DATA_W'(`HP_CTL_RESET);
		ctl_value[`HP_CTL_IRQ_FLAG_A] = flag[0];
		ctl_value[`HP_CTL_IRQ_FLAG_B] = flag[1];
		ctl_value[`HP_CTL_MODE]       = nonmux_reg;
	end

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rdata_reg <= '0;
		end else if (acc_ctl && !acc_write) begin
			rdata_reg <= ctl_value;
		end else if (acc_addr && !acc_write) begin
			rdata_reg <= DATA_W'(addr_reg);
		end else if (state_reg == PORT_MEM_WAIT && mem_ack_in &&
		             !mem_reg.we) begin
			rdata_reg <= mem_rdata_in;
		end
	end

	assign host_data_out    = rdata_reg;
	assign host_data_oe_out = selected & host_ctrl_in.read_write &
	                          ~host_ctrl_in.data_strobe_n &
	                          output_float_n_in;
	assign port_ready_out    = ready;
	assign port_ready_oe_out = output_float_n_in;

endmodule

// ===== testbench/hp_props.sv
// Checker for host port interrupts, modes and reset.
`timescale 1ns/100ps

module hp_props
	import host_port_pkg::*;
#(
	parameter int ADDR_W = 18
) (
	input wire logic              ref_clk_in,
	input wire logic              sys_rst_in,
	input wire logic              host_port_reset_n_in,
	input wire logic              output_float_n_in,
	input wire host_ctrl_t        host_ctrl_in,
	input wire logic [ADDR_W-1:0] host_addr_in,
	input wire logic [15:0]       host_data_in,
	input wire logic              port_ready_out,
	input wire logic              port_ready_oe_out,
	input wire logic              host_irq_n_sub_a_out,
	input wire logic              host_irq_n_sub_a_oe_out,
	input wire logic              host_irq_n_sub_b_out,
	input wire logic              host_irq_n_sub_b_oe_out,
	input wire logic [1:0]        cpu_irq_set_in,
	input wire logic [1:0]        cpu_irq_out,
	input wire logic [1:0]        subsys_reset_out,
	input wire logic              mux_mode_out,
	input wire mem_req_t          mem_req_out
);
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	sequence s_take;
		port_ready_out && host_port_reset_n_in &&
		!host_ctrl_in.port_select_n &&
		!host_ctrl_in.data_strobe_n && $past(host_ctrl_in.data_strobe_n);
	endsequence
	sequence s_ctl_wr;
		s_take ##0 (mux_mode_out && !host_ctrl_in.read_write &&
		!host_ctrl_in.access_select_1 && !host_ctrl_in.access_select_0);
	endsequence
	property p_set;
		mux_mode_out && host_port_reset_n_in && cpu_irq_set_in[0]
		|=> !host_irq_n_sub_a_out;
	endproperty
	property p_set_b;
		mux_mode_out && host_port_reset_n_in && cpu_irq_set_in[1]
		|=> !host_irq_n_sub_b_out;
	endproperty
	property p_float;
		!output_float_n_in |-> !(host_irq_n_sub_a_oe_out ||
		host_irq_n_sub_b_oe_out || port_ready_oe_out);
	endproperty
	property p_nonmux;
		port_ready_out && !mux_mode_out
		|-> host_irq_n_sub_a_out && host_irq_n_sub_b_out;
	endproperty
	property p_hreset;
		!host_port_reset_n_in && cpu_irq_set_in == 2'h0 |=>
		subsys_reset_out == 2'h3 && host_irq_n_sub_a_out;
	endproperty
	property p_clear;
		s_ctl_wr ##0 (host_data_in[2] && !cpu_irq_set_in[0])
		|=> host_irq_n_sub_a_out;
	endproperty
	property p_pulse;
		s_ctl_wr ##0 host_data_in[0] |=> cpu_irq_out[0] ##1 !cpu_irq_out[0];
	endproperty
	property p_data;
		s_take ##0 (host_ctrl_in.access_select_0 || !mux_mode_out)
		|=> mem_req_out.req && !port_ready_out;
	endproperty
	property p_busy;
		mem_req_out.req |-> !port_ready_out;
	endproperty
	property p_naddr;
		s_take ##0 !mux_mode_out |=> mem_req_out.addr == $past(host_addr_in);
	endproperty
	a_set: assert property (p_set) else $error("irq a not set");
	a_set_b: assert property (p_set_b) else $error("irq b not set");
	a_float: assert property (p_float) else $error("pins not floated");
	a_nonmux: assert property (p_nonmux) else $error("irq in non-mux");
	a_hreset: assert property (p_hreset) else $error("port reset");
	a_clear: assert property (p_clear) else $error("irq a not clear");
	a_pulse: assert property (p_pulse) else $error("no cpu irq");
	a_data: assert property (p_data) else $error("no data request");
	a_busy: assert property (p_busy) else $error("ready while busy");
	a_naddr: assert property (p_naddr) else $error("bad address");
endmodule

bind host_port_mode_irq_reset hp_props #(.ADDR_W(ADDR_W)) u_props (.*);

// ===== testbench/host_model.sv
// Host processor model driving the parallel port strobes.
`timescale 1ns/100ps

module host_model
	import host_port_pkg::*;
(
	input  wire logic        ref_clk_in,
	input  wire logic        port_ready_in,
	input  wire logic [15:0] rdata_in,
	output host_ctrl_t       ctrl_out,
	output logic      [17:0] addr_out,
	output logic      [15:0] data_out
);
	int n_err = 0;
	initial begin
		ctrl_out = 6'h3F;
		addr_out = 18'h00000;
		data_out = 16'h0000;
	end
	// ****************************************************************
	// Transfers
	// ****************************************************************
	// Waits are bounded so a stuck port shows up as an error count.
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge ref_clk_in);
			#1;
			n++;
		end while (port_ready_in !== 1'b1 && n < 300);
		if (n >= 300) n_err++;
	endtask
	task automatic xfer(input logic [1:0] sel, input logic rd,
		input logic [15:0] wd, input logic [17:0] a,
		output logic [15:0] rdat);
		wait_ready();
		ctrl_out = {1'b0, sel, rd, 1'b0, 1'b1};
		data_out = rd ? ~data_out : wd;
		addr_out = a;
		@(posedge ref_clk_in);
		wait_ready();
		rdat = rdata_in;
		ctrl_out.data_strobe_n = 1'b1;
		@(posedge ref_clk_in);
		#1;
	endtask
	task automatic addr_load(input logic [15:0] v);
		@(posedge ref_clk_in);
		#1;
		ctrl_out.port_select_n = 1'b0;
		data_out = v;
		ctrl_out.addr_strobe_n = 1'b0;
		@(posedge ref_clk_in);
		#1;
		ctrl_out.addr_strobe_n = 1'b1;
		data_out = ~v;
	endtask
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the host port mode, reset and interrupts.
`timescale 1ns/100ps

module testbench;
	import host_port_pkg::*;
	typedef struct packed {logic [1:0] set; logic [15:0] wr;} row_t;
	logic ref_clk_in = 0, sys_rst_in = 1, host_port_reset_n_in = 1;
	logic host_mux_select_in = 0, output_float_n_in = 1, mem_ack_in = 0;
	host_ctrl_t host_ctrl_in;
	logic [17:0] host_addr_in;
	logic [15:0] host_data_in, host_data_out, mem_rdata_in, rd;
	logic host_data_oe_out, port_ready_out, port_ready_oe_out, mux_mode_out;
	logic host_irq_n_sub_a_out, host_irq_n_sub_a_oe_out;
	logic host_irq_n_sub_b_out, host_irq_n_sub_b_oe_out;
	logic [1:0] cpu_irq_set_in = 0, cpu_irq_out, subsys_reset_out;
	logic [1:0] seen = 0, base, fl, cnt = 0;
	mem_req_t mem_req_out, last;
	int n_fail = 0, n_compared = 0;
	row_t rows [6] = '{'{2'h1, 16'h0004}, '{2'h3, 16'h0004},
		'{2'h0, 16'h0008}, '{2'h0, 16'h0003}, '{2'h2, 16'h0001},
		'{2'h0, 16'h000C}};

	host_port_mode_irq_reset dut (.*);
	host_model host (.ref_clk_in(ref_clk_in), .port_ready_in(port_ready_out),
		.rdata_in(host_data_out), .ctrl_out(host_ctrl_in),
		.addr_out(host_addr_in), .data_out(host_data_in));

	always #5 ref_clk_in = ~ref_clk_in;
	// Read data is only meaningful with ack; otherwise show its bitwise inverse.
	assign mem_rdata_in = mem_req_out.addr[15:0] ^
		(mem_ack_in ? 16'h5A5A : 16'hA5A5);
	always @(posedge ref_clk_in) begin
		cnt <= (mem_req_out.req === 1'b1 && !mem_ack_in) ? cnt + 2'h1 : 2'h0;
		mem_ack_in <= #1 (cnt == 2'h1);
		if (mem_ack_in) last <= mem_req_out;
		seen <= seen ^ cpu_irq_out;
	end

	task automatic chk(input string nm, input logic [17:0] e,
		input logic [17:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic end_of_test();
		if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic pulse(input logic [1:0] s);
		@(posedge ref_clk_in);
		#1 cpu_irq_set_in = s;
		@(posedge ref_clk_in);
		#1 cpu_irq_set_in = 2'h0;
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (4) @(posedge ref_clk_in);
		chk("irq_a", 1, host_irq_n_sub_a_out);
		chk("sub_rst", 3, subsys_reset_out);
		#1 sys_rst_in = 0;
		fl = 2'h0;
		for (int i = 0; i < 6; i++) begin
			pulse(rows[i].set);
			fl = fl | rows[i].set;
			chk("irq_a", !fl[0], host_irq_n_sub_a_out);
			chk("irq_b", !fl[1], host_irq_n_sub_b_out);
			host.xfer(2'h0, 1, 16'h0000, 0, rd);
			chk("ctl", {fl, 2'h0}, rd);
			base = seen;
			host.xfer(2'h0, 0, rows[i].wr, 0, rd);
			fl = fl & ~rows[i].wr[3:2];
			chk("irq_a", !fl[0], host_irq_n_sub_a_out);
			chk("irq_b", !fl[1], host_irq_n_sub_b_out);
			chk("cpu_irq", rows[i].wr[1:0], seen ^ base);
		end
		host.addr_load(16'h1234);
		host.xfer(2'h1, 0, 16'hBEEF, 0, rd);
		chk("addr", 18'h01234, last.addr);
		chk("wdata", 16'hBEEF, last.wdata);
		chk("we", 18'h00001, last.we);
		host.xfer(2'h3, 1, 16'h0000, 0, rd);
		chk("rdata", 16'h1235 ^ 16'h5A5A, rd);
		chk("we", 18'h00000, last.we);
		pulse(2'h1);
		#1 host_port_reset_n_in = 0;
		@(posedge ref_clk_in);
		#1 chk("sub_rst", 3, subsys_reset_out);
		chk("irq_a", 1, host_irq_n_sub_a_out);
		host_mux_select_in = 1;
		@(posedge ref_clk_in);
		#1 host_port_reset_n_in = 1;
		// The strap is only taken when the port leaves reset.
		host.wait_ready();
		chk("mux", 0, mux_mode_out);
		chk("ready", 18'h00001, port_ready_out);
		chk("sub_rst", 18'h00000, subsys_reset_out);
		pulse(2'h3);
		chk("irq_a", 1, host_irq_n_sub_a_out);
		chk("irq_b", 1, host_irq_n_sub_b_out);
		host.xfer(2'h0, 0, 16'hCAFE, 18'h2ABCD, rd);
		chk("addr", 18'h2ABCD, last.addr);
		chk("wdata", 16'hCAFE, last.wdata);
		host.xfer(2'h2, 1, 16'h0000, 18'h3FFFF, rd);
		chk("rdata", 16'hA5A5, rd);
		output_float_n_in = 0;
		@(posedge ref_clk_in);
		#1 chk("oe_a", 0, host_irq_n_sub_a_oe_out);
		chk("oe_b", 0, host_irq_n_sub_b_oe_out);
		chk("oe_rdy", 18'h00000, port_ready_oe_out);
		chk("oe_data", 18'h00000, host_data_oe_out);
		output_float_n_in = 1;
		chk("host_wait", 18'h00000, 18'(host.n_err));
		end_of_test();
	end
	initial begin
		#50000;
		n_fail++;
		end_of_test();
	end
endmodule
